// ---- core/addr_compare.sv ----
// Purpose: Masked comparison of received address bytes with the own address
// Assumes: rx_hi is the first byte after start, rx_lo the second
// Notes:   A set mask bit removes its position from the comparison
module addr_compare
(
   // Comparator carrier
   addr_match_if.cmp m
);

   logic [6:0] miss7;
   logic [9:0] miss10;
   logic [9:0] rx10;

   assign rx10 = {m.rx_hi[2:1], m.rx_lo};

   // ----------------------------------------------------------------
   // Per-bit mismatch terms
   // ----------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < 10; g++)
      begin : g_bit
         assign miss10[g] = ~m.mask[g] & (rx10[g] ^ m.own[g]);
         if (g < 7)
         begin : g_seven
            // Mask bit n steers byte bit n+1, bit 0 of the byte is R/W
            assign miss7[g] = ~m.mask[g] & (m.rx_hi[g + 1] ^ m.own[g]);
         end
      end
   endgenerate

   assign m.hit7     = ~|miss7;
   assign m.hit_hi   = (m.rx_hi[7:3] == addr_mask_pkg::HDR10) & ~|miss10[9:8];
   assign m.hit_full = m.hit_hi & ~|miss10;

endmodule

// ---- core/addr_mask_pkg.sv ----
// Purpose: Shared constants and types for the slave address mask block
// Assumes: 16-bit register port, 4-bit word address
// Notes:   Field positions of the configuration word carried into the link domain
package addr_mask_pkg;

   // ----------------------------------------------------------------
   // Register port
   // ----------------------------------------------------------------
   localparam int unsigned ADDR_W = 4;
   localparam int unsigned DATA_W = 16;

   localparam logic [3:0] REG_MASK_OFS   = 4'h0;
   localparam logic [3:0] REG_OWN_OFS    = 4'h1;
   localparam logic [3:0] REG_CTRL_OFS   = 4'h2;
   localparam logic [3:0] REG_STATUS_OFS = 4'h3;
   localparam logic [3:0] REG_LAST_OFS   = 4'h4;

   // ----------------------------------------------------------------
   // Fields and reset values
   // ----------------------------------------------------------------
   localparam int unsigned MASK_W  = 10;
   localparam int unsigned MASK7_W = 7;

   localparam logic [9:0] MASK_RST = 10'h000;
   localparam logic [9:0] OWN_RST  = 10'h000;
   localparam logic [9:0] LAST_RST = 10'h000;

   localparam int unsigned CTRL_MODE10_BIT = 0;
   localparam int unsigned CTRL_EN_BIT     = 1;
   localparam int unsigned STAT_MATCH_BIT  = 0;
   localparam int unsigned STAT_CFG_BIT    = 1;
   localparam int unsigned STAT_BUSY_BIT   = 2;

   // Configuration word: {en, mode10, own[9:0], mask[9:0]}
   localparam int unsigned CFG_W       = 22;
   localparam int unsigned CFG_MASK_LSB = 0;
   localparam int unsigned CFG_OWN_LSB  = 10;
   localparam int unsigned CFG_MODE_BIT = 20;
   localparam int unsigned CFG_EN_BIT   = 21;
   localparam logic [21:0] CFG_RST      = 22'h000000;

   // ----------------------------------------------------------------
   // Address framing
   // ----------------------------------------------------------------
   localparam logic [4:0] HDR10    = 5'h1E;
   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam logic [2:0] BIT_ONE  = 3'h1;

   // Gray sequence along the address phase
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_RX1  = 3'h1,
      ST_AW1  = 3'h3,
      ST_AD1  = 3'h2,
      ST_RX2  = 3'h6,
      ST_AW2  = 3'h7,
      ST_AD2  = 3'h5,
      ST_HOLD = 3'h4
   } link_state_t;

endpackage

// ---- core/addr_match_if.sv ----
// Purpose: Carrier between the link logic and the address comparator
// Assumes: All signals live in the link clock domain
// Notes:   Purely combinational path, no clock inside
interface addr_match_if;
   logic [9:0] mask;
   logic [9:0] own;
   logic [7:0] rx_hi;
   logic [7:0] rx_lo;
   logic       hit7;
   logic       hit_hi;
   logic       hit_full;

   modport cmp
   (
      input  mask,
      input  own,
      input  rx_hi,
      input  rx_lo,
      output hit7,
      output hit_hi,
      output hit_full
   );

   modport user
   (
      output mask,
      output own,
      output rx_hi,
      output rx_lo,
      input  hit7,
      input  hit_hi,
      input  hit_full
   );
endinterface

// ---- core/i2c_slave_address_mask.sv ----
// Purpose: Two-wire slave address recognition with a software address mask
// Assumes: link_clk_i oversamples SCL/SDA and runs freely; bus master is external
// Notes:   Only the address phase is handled; data bytes are not acknowledged
//
// Added by the designer: the strobed register port and the placing of the registers.
module i2c_slave_address_mask
(
   // System
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   // Register port
   input  wire logic [3:0]  reg_addr_i,
   input  wire logic [15:0] reg_wdata_i,
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   output logic      [15:0] reg_rdata_o,
   // Link
   input  wire logic        link_clk_i,
   input  wire logic        scl_i,
   input  wire logic        sda_i,
   output logic             sda_o,
   output logic             sda_oen_o
);

   // ----------------------------------------------------------------
   // Register side state
   // ----------------------------------------------------------------
   logic [9:0]  mask_reg;
   logic [9:0]  own_reg;
   logic        mode10_reg;
   logic        en_reg;
   logic        matched_reg;
   logic [9:0]  last_addr_reg;
   logic [15:0] rdata_reg;

   logic [21:0] cfg_xfer_reg;
   logic        cfg_req_reg;
   logic        cfg_dirty_reg;
   logic        cack_s1_reg;
   logic        cack_s2_reg;
   logic        evt_s1_reg;
   logic        evt_s2_reg;
   logic        evt_s3_reg;
   logic        busy_s1_reg;
   logic        busy_s2_reg;

   logic        cfg_busy;
   logic        cfg_launch;
   logic        wr_cfg;
   logic        evt_seen;
   logic        wr_mask;
   logic        wr_own;
   logic        wr_ctrl;
   logic        wr_stat;

   // ----------------------------------------------------------------
   // Link side state
   // ----------------------------------------------------------------
   logic        lrst_s1_reg;
   logic        lrst_s2_reg;
   logic        creq_s1_reg;
   logic        creq_s2_reg;
   logic        creq_s3_reg;
   logic [21:0] cfg_link_reg;
   logic        scl_s1_reg;
   logic        scl_s2_reg;
   logic        scl_d_reg;
   logic        sda_s1_reg;
   logic        sda_s2_reg;
   logic        sda_d_reg;

   addr_mask_pkg::link_state_t state_reg;
   logic [2:0]  bit_cnt_reg;
   logic [7:0]  shift_reg;
   logic [7:0]  rx_hi_reg;
   logic [7:0]  rx_lo_reg;
   logic        sda_oen_reg;
   logic        sda_o_reg;
   logic        bus_busy_reg;
   logic        evt_tgl_reg;
   logic [9:0]  hold_addr_reg;
   logic        eack_s1_reg;
   logic        eack_s2_reg;

   logic        link_rst_n;
   logic        start_det;
   logic        stop_det;
   logic        scl_rise;
   logic        scl_fall;
   logic        step;
   logic [7:0]  shift_next;
   logic        l_en;
   logic        l_mode10;
   logic        ack1_ok;
   logic        ack2_ok;
   logic        evt_fire;
   logic        evt_pend;

   addr_match_if am ();

   // ----------------------------------------------------------------
   // Register writes
   // ----------------------------------------------------------------
   assign wr_mask = reg_wr_i & (reg_addr_i == addr_mask_pkg::REG_MASK_OFS);
   assign wr_own  = reg_wr_i & (reg_addr_i == addr_mask_pkg::REG_OWN_OFS);
   assign wr_ctrl = reg_wr_i & (reg_addr_i == addr_mask_pkg::REG_CTRL_OFS);
   assign wr_stat = reg_wr_i & (reg_addr_i == addr_mask_pkg::REG_STATUS_OFS);
   assign wr_cfg  = wr_mask | wr_own | wr_ctrl;

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         mask_reg <= addr_mask_pkg::MASK_RST;
      end
      else if (wr_mask)
      begin
         // Upper six bits are not stored
         mask_reg <= reg_wdata_i[9:0];
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         own_reg    <= addr_mask_pkg::OWN_RST;
         mode10_reg <= 1'b0;
         en_reg     <= 1'b0;
      end
      else
      begin
         if (wr_own)
         begin
            own_reg <= reg_wdata_i[9:0];
         end
         if (wr_ctrl)
         begin
            mode10_reg <= reg_wdata_i[addr_mask_pkg::CTRL_MODE10_BIT];
            en_reg     <= reg_wdata_i[addr_mask_pkg::CTRL_EN_BIT];
         end
      end
   end

   // ----------------------------------------------------------------
   // Configuration hand-off into the link domain
   // ----------------------------------------------------------------
   // Word stays frozen while a request is open, so the link may sample it
   assign cfg_busy   = cfg_req_reg ^ cack_s2_reg;
   assign cfg_launch = ~cfg_busy & cfg_dirty_reg;

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         cfg_xfer_reg  <= addr_mask_pkg::CFG_RST;
         cfg_req_reg   <= 1'b0;
         cfg_dirty_reg <= 1'b0;
      end
      else
      begin
         // A write during launch keeps the dirty flag for a second pass
         cfg_dirty_reg <= wr_cfg | (cfg_dirty_reg & ~cfg_launch);
         if (cfg_launch)
         begin
            cfg_xfer_reg <= {en_reg, mode10_reg, own_reg, mask_reg};
            cfg_req_reg  <= ~cfg_req_reg;
         end
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         cack_s1_reg <= 1'b0;
         cack_s2_reg <= 1'b0;
         evt_s1_reg  <= 1'b0;
         evt_s2_reg  <= 1'b0;
         evt_s3_reg  <= 1'b0;
         busy_s1_reg <= 1'b0;
         busy_s2_reg <= 1'b0;
      end
      else
      begin
         cack_s1_reg <= creq_s3_reg;
         cack_s2_reg <= cack_s1_reg;
         evt_s1_reg  <= evt_tgl_reg;
         evt_s2_reg  <= evt_s1_reg;
         evt_s3_reg  <= evt_s2_reg;
         busy_s1_reg <= bus_busy_reg;
         busy_s2_reg <= busy_s1_reg;
      end
   end

   // ----------------------------------------------------------------
   // Match status
   // ----------------------------------------------------------------
   assign evt_seen = evt_s2_reg ^ evt_s3_reg;

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         matched_reg   <= 1'b0;
         last_addr_reg <= addr_mask_pkg::LAST_RST;
      end
      else
      begin
         // New match beats a clear in the same cycle
         if (evt_seen)
         begin
            matched_reg   <= 1'b1;
            last_addr_reg <= hold_addr_reg;
         end
         else if (wr_stat & reg_wdata_i[addr_mask_pkg::STAT_MATCH_BIT])
         begin
            matched_reg <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Register reads
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         rdata_reg <= 16'h0000;
      end
      else if (reg_rd_i)
      begin
         unique case (reg_addr_i)
            addr_mask_pkg::REG_MASK_OFS:   rdata_reg <= {6'h00, mask_reg};
            addr_mask_pkg::REG_OWN_OFS:    rdata_reg <= {6'h00, own_reg};
            addr_mask_pkg::REG_CTRL_OFS:   rdata_reg <= {14'h0000, en_reg, mode10_reg};
            addr_mask_pkg::REG_STATUS_OFS:
               rdata_reg <= {13'h0000, busy_s2_reg, cfg_busy | cfg_dirty_reg, matched_reg};
            addr_mask_pkg::REG_LAST_OFS:   rdata_reg <= {6'h00, last_addr_reg};
            default:                       rdata_reg <= 16'h0000;
         endcase
      end
      else
      begin
         rdata_reg <= 16'h0000;
      end
   end

   assign reg_rdata_o = rdata_reg;

   // ----------------------------------------------------------------
   // Link domain reset and crossings
   // ----------------------------------------------------------------
   always_ff @(posedge link_clk_i)
   begin
      lrst_s1_reg <= rst_n_i;
      lrst_s2_reg <= lrst_s1_reg;
   end

   assign link_rst_n = lrst_s2_reg;

   always_ff @(posedge link_clk_i)
   begin
      if (!link_rst_n)
      begin
         creq_s1_reg  <= 1'b0;
         creq_s2_reg  <= 1'b0;
         creq_s3_reg  <= 1'b0;
         cfg_link_reg <= addr_mask_pkg::CFG_RST;
         eack_s1_reg  <= 1'b0;
         eack_s2_reg  <= 1'b0;
      end
      else
      begin
         creq_s1_reg <= cfg_req_reg;
         creq_s2_reg <= creq_s1_reg;
         creq_s3_reg <= creq_s2_reg;
         eack_s1_reg <= evt_s3_reg;
         eack_s2_reg <= eack_s1_reg;
         if (creq_s2_reg ^ creq_s3_reg)
         begin
            cfg_link_reg <= cfg_xfer_reg;
         end
      end
   end

   always_ff @(posedge link_clk_i)
   begin
      if (!link_rst_n)
      begin
         scl_s1_reg <= 1'b1;
         scl_s2_reg <= 1'b1;
         scl_d_reg  <= 1'b1;
         sda_s1_reg <= 1'b1;
         sda_s2_reg <= 1'b1;
         sda_d_reg  <= 1'b1;
      end
      else
      begin
         scl_s1_reg <= scl_i;
         scl_s2_reg <= scl_s1_reg;
         scl_d_reg  <= scl_s2_reg;
         sda_s1_reg <= sda_i;
         sda_s2_reg <= sda_s1_reg;
         sda_d_reg  <= sda_s2_reg;
      end
   end

   // ----------------------------------------------------------------
   // Bus conditions and comparator
   // ----------------------------------------------------------------
   assign start_det  = scl_s2_reg & scl_d_reg & sda_d_reg & ~sda_s2_reg;
   assign stop_det   = scl_s2_reg & scl_d_reg & ~sda_d_reg & sda_s2_reg;
   assign scl_rise   = scl_s2_reg & ~scl_d_reg;
   assign scl_fall   = ~scl_s2_reg & scl_d_reg;
   assign step       = ~start_det & ~stop_det;
   assign shift_next = {shift_reg[6:0], sda_s2_reg};

   assign l_en     = cfg_link_reg[addr_mask_pkg::CFG_EN_BIT];
   assign l_mode10 = cfg_link_reg[addr_mask_pkg::CFG_MODE_BIT];

   assign am.mask  = cfg_link_reg[addr_mask_pkg::CFG_MASK_LSB +: addr_mask_pkg::MASK_W];
   assign am.own   = cfg_link_reg[addr_mask_pkg::CFG_OWN_LSB +: addr_mask_pkg::MASK_W];
   assign am.rx_hi = rx_hi_reg;
   assign am.rx_lo = rx_lo_reg;

   addr_compare u_cmp
   (
      .m (am.cmp)
   );

   // 10-bit header only answered for a write, read turnaround is not handled
   assign ack1_ok = l_en & (l_mode10 ? (am.hit_hi & ~rx_hi_reg[0]) : am.hit7);
   assign ack2_ok = l_en & am.hit_full;

   // ----------------------------------------------------------------
   // Address phase sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge link_clk_i)
   begin
      if (!link_rst_n)
      begin
         state_reg   <= addr_mask_pkg::ST_IDLE;
         bit_cnt_reg <= 3'h0;
         shift_reg   <= 8'h00;
         rx_hi_reg   <= 8'h00;
         rx_lo_reg   <= 8'h00;
         sda_oen_reg <= 1'b1;
      end
      else if (start_det)
      begin
         state_reg   <= addr_mask_pkg::ST_RX1;
         bit_cnt_reg <= 3'h0;
         sda_oen_reg <= 1'b1;
      end
      else if (stop_det)
      begin
         state_reg   <= addr_mask_pkg::ST_IDLE;
         sda_oen_reg <= 1'b1;
      end
      else
      begin
         unique case (state_reg)
            addr_mask_pkg::ST_RX1, addr_mask_pkg::ST_RX2:
            begin
               if (scl_rise)
               begin
                  shift_reg   <= shift_next;
                  bit_cnt_reg <= bit_cnt_reg + addr_mask_pkg::BIT_ONE;
                  if (bit_cnt_reg == addr_mask_pkg::BIT_LAST)
                  begin
                     if (state_reg == addr_mask_pkg::ST_RX1)
                     begin
                        rx_hi_reg <= shift_next;
                        state_reg <= addr_mask_pkg::ST_AW1;
                     end
                     else
                     begin
                        rx_lo_reg <= shift_next;
                        state_reg <= addr_mask_pkg::ST_AW2;
                     end
                  end
               end
            end
            addr_mask_pkg::ST_AW1:
            begin
               if (scl_fall)
               begin
                  sda_oen_reg <= ~ack1_ok;
                  state_reg   <= ack1_ok ? addr_mask_pkg::ST_AD1 : addr_mask_pkg::ST_HOLD;
               end
            end
            addr_mask_pkg::ST_AD1:
            begin
               if (scl_fall)
               begin
                  sda_oen_reg <= 1'b1;
                  bit_cnt_reg <= 3'h0;
                  state_reg   <= l_mode10 ? addr_mask_pkg::ST_RX2 : addr_mask_pkg::ST_HOLD;
               end
            end
            addr_mask_pkg::ST_AW2:
            begin
               if (scl_fall)
               begin
                  sda_oen_reg <= ~ack2_ok;
                  state_reg   <= ack2_ok ? addr_mask_pkg::ST_AD2 : addr_mask_pkg::ST_HOLD;
               end
            end
            addr_mask_pkg::ST_AD2:
            begin
               if (scl_fall)
               begin
                  sda_oen_reg <= 1'b1;
                  state_reg   <= addr_mask_pkg::ST_HOLD;
               end
            end
            addr_mask_pkg::ST_IDLE, addr_mask_pkg::ST_HOLD:
            begin
               state_reg <= state_reg;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Bus busy level and match event
   // ----------------------------------------------------------------
   always_ff @(posedge link_clk_i)
   begin
      if (!link_rst_n)
      begin
         bus_busy_reg <= 1'b0;
         sda_o_reg    <= 1'b0;
      end
      else
      begin
         sda_o_reg <= 1'b0;
         if (start_det)
         begin
            bus_busy_reg <= 1'b1;
         end
         else if (stop_det)
         begin
            bus_busy_reg <= 1'b0;
         end
      end
   end

   // A match while the previous one is unacknowledged is dropped
   assign evt_pend = evt_tgl_reg ^ eack_s2_reg;
   assign evt_fire = step & scl_fall &
                     (((state_reg == addr_mask_pkg::ST_AW1) & ack1_ok & ~l_mode10) |
                      ((state_reg == addr_mask_pkg::ST_AW2) & ack2_ok));

   always_ff @(posedge link_clk_i)
   begin
      if (!link_rst_n)
      begin
         evt_tgl_reg   <= 1'b0;
         hold_addr_reg <= addr_mask_pkg::LAST_RST;
      end
      else if (evt_fire & ~evt_pend)
      begin
         evt_tgl_reg   <= ~evt_tgl_reg;
         hold_addr_reg <= l_mode10 ? {rx_hi_reg[2:1], rx_lo_reg} : {3'h0, rx_hi_reg[7:1]};
      end
   end

   assign sda_o     = sda_o_reg;
   assign sda_oen_o = sda_oen_reg;

endmodule

// ---- verification/i2c_bus_master_model.sv ----
// Purpose: Two-wire bus master driving address frames
// Assumes: Pull-up on both lines; 1 on an output means released
// Notes:   Bus clock stands high between frames
module i2c_bus_master_model
(
   // Bus
   output logic      scl_o,
   output logic      sda_o,
   input  wire logic sda_i
);
   timeunit 1ns;
   timeprecision 100ps;

   localparam int HALF = 200;

   initial
   begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end

   task automatic frame_start();
      sda_o = 1'b1;
      scl_o = 1'b1;
      #HALF sda_o = 1'b0;
      #HALF scl_o = 1'b0;
   endtask

   // Data moves 50 ns into the low phase, clear of the slave's release
   task automatic send_byte(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--)
      begin
         #50 sda_o = b[i];
         #150 scl_o = 1'b1;
         #HALF scl_o = 1'b0;
      end
      #50 sda_o = 1'b1;
      #150 scl_o = 1'b1;
      #(HALF / 2) ack = !sda_i;
      #(HALF / 2) scl_o = 1'b0;
   endtask

   task automatic frame_stop();
      #50 sda_o = 1'b0;
      #150 scl_o = 1'b1;
      #HALF sda_o = 1'b1;
      #HALF;
   endtask
endmodule

// ---- verification/i2c_slave_address_mask_checker.sv ----
// Purpose: Port-level assertions for the address mask block
// Assumes: Single system clock; link pins seen as sampled on clk_i
// Notes:   Shadows of mask and enable kept from register writes
module i2c_slave_address_mask_checker
(
   // System
   input wire logic        clk_i,
   input wire logic        rst_n_i,
   // Register port
   input wire logic [3:0]  reg_addr_i,
   input wire logic [15:0] reg_wdata_i,
   input wire logic        reg_wr_i,
   input wire logic        reg_rd_i,
   input wire logic [15:0] reg_rdata_o,
   // Link
   input wire logic        scl_i,
   input wire logic        sda_o,
   input wire logic        sda_oen_o
);
   logic [9:0] mask_shadow_reg;
   logic       en_shadow_reg;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
         mask_shadow_reg <= 10'h000;
      else if (reg_wr_i && reg_addr_i == addr_mask_pkg::REG_MASK_OFS)
         mask_shadow_reg <= reg_wdata_i[9:0];
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
         en_shadow_reg <= 1'b0;
      else if (reg_wr_i && reg_addr_i == addr_mask_pkg::REG_CTRL_OFS)
         en_shadow_reg <= reg_wdata_i[addr_mask_pkg::CTRL_EN_BIT];
   end

   sequence s_ack_start;
      $fell(sda_oen_o);
   endsequence

   sequence s_mask_read;
      reg_rd_i && reg_addr_i == addr_mask_pkg::REG_MASK_OFS;
   endsequence

   a_rdata_quiet: assert property (!reg_rd_i |=> reg_rdata_o == 16'h0000)
      else $error("read data not zero outside read answer");
   a_mask_readback: assert property (s_mask_read |=>
      reg_rdata_o == {6'h00, $past(mask_shadow_reg)})
      else $error("mask read back wrong");
   a_unmapped_zero: assert property (reg_rd_i && reg_addr_i > 4'h4 |=> reg_rdata_o == 16'h0000)
      else $error("unmapped read not zero");
   a_drive_low: assert property (sda_o == 1'b0)
      else $error("data drive value not low");
   a_ack_scl_low: assert property (s_ack_start |-> !scl_i)
      else $error("acknowledge started while bus clock high");
   a_ack_hold: assert property (s_ack_start |=> !sda_oen_o [*8])
      else $error("acknowledge too short");
   a_ack_release: assert property (s_ack_start |-> ##[1:1000] $rose(sda_oen_o))
      else $error("acknowledge never released");
   a_oen_scl_high: assert property (scl_i && $past(scl_i) |-> $stable(sda_oen_o))
      else $error("data enable moved while bus clock high");
   a_ack_needs_en: assert property (s_ack_start |-> en_shadow_reg)
      else $error("acknowledge while disabled");
endmodule

bind i2c_slave_address_mask i2c_slave_address_mask_checker u_chk
(
   .clk_i       (clk_i),
   .rst_n_i     (rst_n_i),
   .reg_addr_i  (reg_addr_i),
   .reg_wdata_i (reg_wdata_i),
   .reg_wr_i    (reg_wr_i),
   .reg_rd_i    (reg_rd_i),
   .reg_rdata_o (reg_rdata_o),
   .scl_i       (scl_i),
   .sda_o       (sda_o),
   .sda_oen_o   (sda_oen_o)
);

// ---- verification/i2c_slave_address_mask_tb.sv ----
// Purpose: Self-checking bench for the address mask block
// Assumes: Bus master model on the link side
// Notes:   Expectations worked from own address, mask and mode
module i2c_slave_address_mask_tb;
   timeunit 1ns;
   timeprecision 100ps;

   typedef struct {logic [1:0] ctrl; logic [9:0] own; logic [9:0] mask; logic [9:0] addr;} case_t;

   logic        clk_i, rst_n_i, link_clk_i, reg_wr_i, reg_rd_i;
   logic [3:0]  reg_addr_i;
   logic [15:0] reg_wdata_i, reg_rdata_o, d;
   logic        scl_i, sda_i, sda_o, sda_oen_o, m_sda, rd_ack;
   int          n_mismatch, comparisons, cycles;
   case_t       cases [11];

   // Wired-and of both parties on the pulled-up data line
   assign sda_i = sda_oen_o ? m_sda : (m_sda & sda_o);

   i2c_slave_address_mask u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
      .reg_rdata_o(reg_rdata_o), .link_clk_i(link_clk_i), .scl_i(scl_i), .sda_i(sda_i),
      .sda_o(sda_o), .sda_oen_o(sda_oen_o));

   i2c_bus_master_model u_mst (.scl_o(scl_i), .sda_o(m_sda), .sda_i(sda_i));

   initial
   begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end

   initial
   begin
      link_clk_i = 1'b0;
      #7.3;
      forever #16 link_clk_i = ~link_clk_i;
   end

   task automatic give_verdict();
      $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   always @(posedge clk_i)
   begin
      cycles++;
      if (cycles == 60000)
      begin
         n_mismatch++;
         give_verdict();
      end
   end

   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      comparisons++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic reg_write(input logic [3:0] a, input logic [15:0] v);
      @(posedge clk_i);
      reg_addr_i  <= a;
      reg_wdata_i <= v;
      reg_wr_i    <= 1'b1;
      @(posedge clk_i);
      reg_wr_i    <= 1'b0;
   endtask

   task automatic reg_read(input logic [3:0] a, output logic [15:0] v);
      @(posedge clk_i);
      reg_addr_i <= a;
      reg_rd_i   <= 1'b1;
      @(posedge clk_i);
      reg_rd_i   <= 1'b0;
      #1 v = reg_rdata_o;
   endtask

   task automatic wait_status(input int idx, input logic val);
      logic [15:0] s;
      reg_read(addr_mask_pkg::REG_STATUS_OFS, s);
      for (int i = 0; i < 80 && s[idx] !== val; i++)
         reg_read(addr_mask_pkg::REG_STATUS_OFS, s);
      check("status bit", 16'(val), 16'(s[idx]));
   endtask

   task automatic run_case(input case_t c);
      logic [9:0] diff;
      logic       e1, e2, ack;
      diff = (c.addr ^ c.own) & ~c.mask;
      reg_write(addr_mask_pkg::REG_CTRL_OFS, {14'h0000, c.ctrl});
      reg_write(addr_mask_pkg::REG_OWN_OFS, {6'h00, c.own});
      reg_write(addr_mask_pkg::REG_MASK_OFS, {6'h00, c.mask});
      wait_status(addr_mask_pkg::STAT_CFG_BIT, 1'b0);
      e1 = c.ctrl[1] && (c.ctrl[0] ? diff[9:8] == 2'h0 : diff[6:0] == 7'h00);
      e2 = c.ctrl[1] && (c.ctrl[0] ? diff == 10'h000 : e1);
      u_mst.frame_start();
      wait_status(addr_mask_pkg::STAT_BUSY_BIT, 1'b1);
      if (c.ctrl[0])
         u_mst.send_byte({addr_mask_pkg::HDR10, c.addr[9:8], 1'b0}, ack);
      else
         u_mst.send_byte({c.addr[6:0], 1'b0}, ack);
      check("ack first byte", 16'(e1), 16'(ack));
      if (c.ctrl[0] && ack)
      begin
         u_mst.send_byte(c.addr[7:0], ack);
         check("ack second byte", 16'(e2), 16'(ack));
      end
      u_mst.frame_stop();
      wait_status(addr_mask_pkg::STAT_BUSY_BIT, 1'b0);
      if (e2)
      begin
         wait_status(addr_mask_pkg::STAT_MATCH_BIT, 1'b1);
         reg_read(addr_mask_pkg::REG_LAST_OFS, d);
         check("last address", c.ctrl[0] ? {6'h00, c.addr} : {9'h000, c.addr[6:0]}, d);
         reg_write(addr_mask_pkg::REG_STATUS_OFS, 16'h0001);
         wait_status(addr_mask_pkg::STAT_MATCH_BIT, 1'b0);
      end
   endtask

   initial
   begin
      cases = '{
         '{2'h2, 10'h02A, 10'h000, 10'h02A},
         '{2'h2, 10'h02A, 10'h000, 10'h02B},
         '{2'h2, 10'h02A, 10'h001, 10'h02B},
         '{2'h2, 10'h02A, 10'h002, 10'h02B},
         '{2'h2, 10'h02A, 10'h380, 10'h02B},
         '{2'h3, 10'h2A5, 10'h000, 10'h2A5},
         '{2'h3, 10'h2A5, 10'h000, 10'h2A4},
         '{2'h3, 10'h2A5, 10'h001, 10'h2A4},
         '{2'h3, 10'h2A5, 10'h100, 10'h3A5},
         '{2'h3, 10'h2A5, 10'h000, 10'h3A5},
         '{2'h0, 10'h02A, 10'h000, 10'h02A}};
      rst_n_i     = 1'b0;
      reg_addr_i  = 4'h0;
      reg_wdata_i = 16'h0000;
      reg_wr_i    = 1'b0;
      reg_rd_i    = 1'b0;
      // Link reset is synchronised, so hold well past two cycles
      repeat (40) @(posedge clk_i);
      rst_n_i <= 1'b1;
      for (int a = 0; a < 5; a++)
      begin
         reg_read(4'(a), d);
         check("reset value", 16'h0000, d);
      end
      reg_write(addr_mask_pkg::REG_MASK_OFS, 16'hFFFF);
      reg_read(addr_mask_pkg::REG_MASK_OFS, d);
      check("mask upper bits", 16'h03FF, d);
      reg_write(4'hF, 16'hFFFF);
      reg_read(4'hF, d);
      check("unmapped read", 16'h0000, d);
      reg_write(addr_mask_pkg::REG_LAST_OFS, 16'hFFFF);
      reg_read(addr_mask_pkg::REG_LAST_OFS, d);
      check("read-only last", 16'h0000, d);
      foreach (cases[i])
         run_case(cases[i]);
      // Header with the read bit set is never answered in 10-bit mode
      reg_write(addr_mask_pkg::REG_CTRL_OFS, 16'h0003);
      wait_status(addr_mask_pkg::STAT_CFG_BIT, 1'b0);
      u_mst.frame_start();
      u_mst.send_byte({addr_mask_pkg::HDR10, 2'h0, 1'b1}, rd_ack);
      check("read header", 16'h0000, 16'(rd_ack));
      u_mst.frame_stop();
      give_verdict();
   end
endmodule
